// *** src/adcsg_acc.sv ***
// Purpose: Running sum of repeated conversions of one channel
// Assumes: Inputs come from logic on the same clock
// Notes: The first sample of a channel overwrites, so no separate clear is needed
`timescale 1ns/1ns
`default_nettype none
module adcsg_acc (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic add,
	input wire logic first,
	input wire logic [adcsg_pkg::DATA_W-1:0] din,
	output logic [adcsg_pkg::SUM_W-1:0] sum
);
	logic [adcsg_pkg::SUM_W-1:0] sum_reg;
	logic [adcsg_pkg::SUM_W-1:0] din_ext;

	// Sixteen 12-bit samples fit exactly in 16 bits
	assign din_ext = adcsg_pkg::SUM_W'(din);
	assign sum = sum_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sum_reg <= '0;
		end else if (add) begin
			sum_reg <= first ? din_ext : sum_reg + din_ext;
		end
	end
endmodule
`default_nettype wire

// *** src/adcsg_pick.sv ***
// Purpose: Finds the lowest enabled channel at or above a start index
// Assumes: Purely combinational, read by the scan engine in the same cycle
// Notes: A start index past the last channel yields no hit
`timescale 1ns/1ns
`default_nettype none
module adcsg_pick (
	input wire logic [adcsg_pkg::CH_N-1:0] mask,
	input wire logic [adcsg_pkg::CH_W-1:0] from,
	output logic found,
	output logic [adcsg_pkg::CH_W-1:0] chan
);
	always_comb begin
		found = 1'b0;
		chan = '0;
		for (int i = adcsg_pkg::CH_N - 1; i >= 0; i--) begin
			if (mask[i] && (i >= int'(from))) begin
				found = 1'b1;
				chan = adcsg_pkg::CH_W'(i);
			end
		end
	end
endmodule
`default_nettype wire

// *** src/adcsg_pkg.sv ***
// Purpose: Shared constants and types of the ADC scan group and averaging control
// Assumes: APB register access, one 250 MHz clock, channel index 0..29
// Notes: Indices 28 and 29 are the temperature and voltage sensor inputs
package adcsg_pkg;
	localparam int CH_N = 30;
	localparam int CH_W = 5;
	localparam int DATA_W = 12;
	localparam int SUM_W = 16;
	localparam int ADDR_W = 8;
	localparam int CH_TEMP = 28;
	localparam int CH_VOLT = 29;
	localparam int PCLK_MHZ = 250;

	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SEL_A = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_SEL_B = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_ACC_MASK = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h14;

	localparam int CTRL_GROUP_BIT = 0;
	localparam int CTRL_CONT_BIT = 1;
	localparam int CTRL_PRIO_LSB = 2;
	localparam int CTRL_ACC_LSB = 4;
	localparam int CTRL_START_BIT = 8;

	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_GRP_BIT = 1;
	localparam int STAT_PEND_A_BIT = 2;
	localparam int STAT_PEND_B_BIT = 3;
	localparam int STAT_RESUME_BIT = 4;
	localparam int STAT_CHAN_LSB = 8;

	localparam int RES_DATA_LSB = 0;
	localparam int RES_CHAN_LSB = 16;
	localparam int RES_GRP_BIT = 24;

	localparam logic [CH_N-1:0] MASK_RST = 30'h0000_0000;
	localparam logic [CH_W-1:0] ONE_REP = 5'h01;

	typedef enum logic [1:0] {
		PRIO_NONE = 2'h0,
		PRIO_ABORT = 2'h1,
		PRIO_RESTART = 2'h2,
		PRIO_CONT = 2'h3
	} adcsg_prio_t;

	typedef enum logic [2:0] {
		ACC_OFF = 3'h0,
		ACC_ADD2 = 3'h1,
		ACC_ADD3 = 3'h2,
		ACC_ADD4 = 3'h3,
		ACC_ADD16 = 3'h4,
		ACC_AVG2 = 3'h5,
		ACC_AVG4 = 3'h6
	} adcsg_acc_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_ISSUE = 2'h1,
		ST_WAIT = 2'h3,
		ST_EMIT = 2'h2
	} adcsg_state_t;

	typedef struct packed {
		logic grp;
		logic [CH_W-1:0] chan;
		logic [SUM_W-1:0] data;
	} adcsg_res_t;
endpackage

// *** src/adcsg_top.sv ***
// Purpose: Scan control with group A/B arbitration and sample add/average
// Assumes: APB slave with one wait state; converter handshake on the same clock
// Notes: Preemption of group B takes effect when the result of the channel in flight is emitted, after all its repeats
//
// Contract
// - In normal scan the select mask enables channel n through bit n.
// - In group scan each channel 0-29 is unused, in group A or in group B.
// - In group scan only event-link triggers start either group, never software.
// - Under the reset priority policy group A never preempts a running group B.
// - Under the fourth policy group B restarts after group A and then loops.
// - Accumulation sums 2, 3, 4 or 16 conversions per channel and is off at reset.
// - Averaging returns the mean of 2 or 4 conversions per channel.
// - Accumulation applies only to masked channels and the mask is unused when off.
// - The temperature and voltage sensor inputs take part in the scan masks.
// - The temperature and voltage sensor inputs have their own accumulation mask bits.
`timescale 1ns/1ns
`default_nettype none
module adcsg_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adcsg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic event_link_trigger_a,
	input wire logic event_link_trigger_b,
	output logic conv_req,
	output logic [adcsg_pkg::CH_W-1:0] conv_chan,
	input wire logic conv_done,
	input wire logic [adcsg_pkg::DATA_W-1:0] conv_data,
	output logic res_valid,
	output adcsg_pkg::adcsg_res_t res
);
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic group_reg;
	logic cont_reg;
	adcsg_pkg::adcsg_prio_t prio_reg;
	adcsg_pkg::adcsg_acc_t acc_reg;
	logic sw_start_reg;
	logic [adcsg_pkg::CH_N-1:0] sel_a_reg;
	logic [adcsg_pkg::CH_N-1:0] sel_b_reg;
	logic [adcsg_pkg::CH_N-1:0] acc_mask_reg;
	adcsg_pkg::adcsg_state_t state_reg;
	logic grp_reg;
	logic [adcsg_pkg::CH_W-1:0] idx_reg;
	logic [adcsg_pkg::CH_W-1:0] rep_reg;
	logic [adcsg_pkg::CH_W-1:0] cur_chan_reg;
	logic pend_a_reg;
	logic pend_b_reg;
	logic resume_b_reg;
	logic conv_req_reg;
	logic [adcsg_pkg::CH_W-1:0] conv_chan_reg;
	logic res_valid_reg;
	adcsg_pkg::adcsg_res_t res_reg;

	logic access;
	logic wr_en;
	logic start_a_ev;
	logic start_b_ev;
	logic want_a;
	logic want_b;
	logic go_a;
	logic go_b;
	logic preempt;
	logic [adcsg_pkg::CH_N-1:0] mask_a;
	logic [adcsg_pkg::CH_N-1:0] mask_b;
	logic [adcsg_pkg::CH_N-1:0] scan_mask;
	logic pick_found;
	logic [adcsg_pkg::CH_W-1:0] pick_chan;
	logic [adcsg_pkg::SUM_W-1:0] acc_sum;
	logic acc_on;
	logic [adcsg_pkg::CH_W-1:0] reps;
	logic [adcsg_pkg::CH_W-1:0] rep_inc;

	function automatic logic [adcsg_pkg::CH_W-1:0] acc_reps(input adcsg_pkg::adcsg_acc_t code);
		case (code)
			adcsg_pkg::ACC_ADD2: acc_reps = 5'h02;
			adcsg_pkg::ACC_ADD3: acc_reps = 5'h03;
			adcsg_pkg::ACC_ADD4: acc_reps = 5'h04;
			adcsg_pkg::ACC_ADD16: acc_reps = 5'h10;
			adcsg_pkg::ACC_AVG2: acc_reps = 5'h02;
			adcsg_pkg::ACC_AVG4: acc_reps = 5'h04;
			default: acc_reps = adcsg_pkg::ONE_REP;
		endcase
	endfunction

	function automatic logic [1:0] acc_shift(input adcsg_pkg::adcsg_acc_t code);
		case (code)
			adcsg_pkg::ACC_AVG2: acc_shift = 2'h1;
			adcsg_pkg::ACC_AVG4: acc_shift = 2'h2;
			default: acc_shift = 2'h0;
		endcase
	endfunction

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign conv_req = conv_req_reg;
	assign conv_chan = conv_chan_reg;
	assign res_valid = res_valid_reg;
	assign res = res_reg;

	// One wait state lets read data come from a flop
	assign access = psel && penable;
	assign wr_en = access && pwrite && pready_reg;

	// Channels claimed by both masks stay in group A
	assign mask_a = sel_a_reg;
	assign mask_b = group_reg ? (sel_b_reg & ~sel_a_reg) : adcsg_pkg::MASK_RST;
	assign scan_mask = grp_reg ? mask_b : mask_a;

	assign start_a_ev = event_link_trigger_a || (!group_reg && sw_start_reg);
	assign start_b_ev = group_reg && event_link_trigger_b;
	assign want_a = pend_a_reg || start_a_ev;
	assign want_b = pend_b_reg || start_b_ev;

	assign preempt = (state_reg == adcsg_pkg::ST_EMIT) && grp_reg && group_reg &&
		(prio_reg != adcsg_pkg::PRIO_NONE) && want_a;

	assign acc_on = (acc_reg != adcsg_pkg::ACC_OFF) && acc_mask_reg[cur_chan_reg];
	assign reps = acc_on ? acc_reps(acc_reg) : adcsg_pkg::ONE_REP;
	assign rep_inc = rep_reg + adcsg_pkg::ONE_REP;

	adcsg_pick u_pick (
		.mask(scan_mask),
		.from(idx_reg),
		.found(pick_found),
		.chan(pick_chan)
	);

	adcsg_acc u_acc (
		.pclk(pclk),
		.presetn(presetn),
		.add((state_reg == adcsg_pkg::ST_WAIT) && conv_done),
		.first(rep_reg == '0),
		.din(conv_data),
		.sum(acc_sum)
	);

	always_comb begin
		go_a = 1'b0;
		go_b = 1'b0;
		case (state_reg)
			adcsg_pkg::ST_IDLE: begin
				if (want_a) begin
					go_a = 1'b1;
				end else if (want_b) begin
					go_b = 1'b1;
				end
			end
			adcsg_pkg::ST_ISSUE: begin
				if (!pick_found && !grp_reg) begin
					if (resume_b_reg && group_reg) begin
						go_b = 1'b1;
					end else if (want_b) begin
						go_b = 1'b1;
					end else if (want_a || (!group_reg && cont_reg)) begin
						go_a = 1'b1;
					end
				end else if (!pick_found) begin
					if (want_a) begin
						go_a = 1'b1;
					end else if (group_reg && prio_reg == adcsg_pkg::PRIO_CONT) begin
						go_b = 1'b1;
					end else if (want_b) begin
						go_b = 1'b1;
					end
				end
			end
			adcsg_pkg::ST_EMIT: begin
				go_a = preempt;
			end
			default: begin
				go_a = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
		end else if (access && !pready_reg) begin
			pready_reg <= 1'b1;
			pslverr_reg <= 1'b0;
			prdata_reg <= '0;
			case (paddr)
				adcsg_pkg::OFF_CTRL: begin
					prdata_reg[adcsg_pkg::CTRL_GROUP_BIT] <= group_reg;
					prdata_reg[adcsg_pkg::CTRL_CONT_BIT] <= cont_reg;
					prdata_reg[adcsg_pkg::CTRL_PRIO_LSB +: 2] <= prio_reg;
					prdata_reg[adcsg_pkg::CTRL_ACC_LSB +: 3] <= acc_reg;
				end
				adcsg_pkg::OFF_SEL_A: prdata_reg[adcsg_pkg::CH_N-1:0] <= sel_a_reg;
				adcsg_pkg::OFF_SEL_B: prdata_reg[adcsg_pkg::CH_N-1:0] <= sel_b_reg;
				adcsg_pkg::OFF_ACC_MASK: prdata_reg[adcsg_pkg::CH_N-1:0] <= acc_mask_reg;
				adcsg_pkg::OFF_STATUS: begin
					prdata_reg[adcsg_pkg::STAT_BUSY_BIT] <= state_reg != adcsg_pkg::ST_IDLE;
					prdata_reg[adcsg_pkg::STAT_GRP_BIT] <= grp_reg;
					prdata_reg[adcsg_pkg::STAT_PEND_A_BIT] <= pend_a_reg;
					prdata_reg[adcsg_pkg::STAT_PEND_B_BIT] <= pend_b_reg;
					prdata_reg[adcsg_pkg::STAT_RESUME_BIT] <= resume_b_reg;
					prdata_reg[adcsg_pkg::STAT_CHAN_LSB +: adcsg_pkg::CH_W] <= cur_chan_reg;
				end
				adcsg_pkg::OFF_RESULT: begin
					prdata_reg[adcsg_pkg::RES_DATA_LSB +: adcsg_pkg::SUM_W] <= res_reg.data;
					prdata_reg[adcsg_pkg::RES_CHAN_LSB +: adcsg_pkg::CH_W] <= res_reg.chan;
					prdata_reg[adcsg_pkg::RES_GRP_BIT] <= res_reg.grp;
				end
				default: pslverr_reg <= 1'b1;
			endcase
		end else begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			group_reg <= 1'b0;
			cont_reg <= 1'b0;
			prio_reg <= adcsg_pkg::PRIO_NONE;
			acc_reg <= adcsg_pkg::ACC_OFF;
			sel_a_reg <= adcsg_pkg::MASK_RST;
			sel_b_reg <= adcsg_pkg::MASK_RST;
			acc_mask_reg <= adcsg_pkg::MASK_RST;
		end else if (wr_en) begin
			case (paddr)
				adcsg_pkg::OFF_CTRL: begin
					group_reg <= pwdata[adcsg_pkg::CTRL_GROUP_BIT];
					cont_reg <= pwdata[adcsg_pkg::CTRL_CONT_BIT];
					prio_reg <= adcsg_pkg::adcsg_prio_t'(pwdata[adcsg_pkg::CTRL_PRIO_LSB +: 2]);
					acc_reg <= adcsg_pkg::adcsg_acc_t'(pwdata[adcsg_pkg::CTRL_ACC_LSB +: 3]);
				end
				adcsg_pkg::OFF_SEL_A: sel_a_reg <= pwdata[adcsg_pkg::CH_N-1:0];
				adcsg_pkg::OFF_SEL_B: sel_b_reg <= pwdata[adcsg_pkg::CH_N-1:0];
				adcsg_pkg::OFF_ACC_MASK: acc_mask_reg <= pwdata[adcsg_pkg::CH_N-1:0];
				default: sel_a_reg <= sel_a_reg;
			endcase
		end
	end

	// Software start is a one-cycle pulse; it is ignored in group mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_start_reg <= 1'b0;
		end else begin
			sw_start_reg <= wr_en && (paddr == adcsg_pkg::OFF_CTRL) &&
				pwdata[adcsg_pkg::CTRL_START_BIT];
		end
	end

	// A trigger that lands while its request is taken is merged into that scan
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_a_reg <= 1'b0;
			pend_b_reg <= 1'b0;
		end else begin
			pend_a_reg <= want_a && !go_a;
			pend_b_reg <= group_reg && want_b && !go_b;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resume_b_reg <= 1'b0;
		end else if (preempt || (go_a && grp_reg && prio_reg == adcsg_pkg::PRIO_CONT)) begin
			resume_b_reg <= prio_reg != adcsg_pkg::PRIO_ABORT;
		end else if (go_b || !group_reg) begin
			resume_b_reg <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= adcsg_pkg::ST_IDLE;
			grp_reg <= 1'b0;
			idx_reg <= '0;
			rep_reg <= '0;
			cur_chan_reg <= '0;
			conv_req_reg <= 1'b0;
			conv_chan_reg <= '0;
			res_valid_reg <= 1'b0;
			res_reg <= '0;
		end else begin
			conv_req_reg <= 1'b0;
			res_valid_reg <= 1'b0;
			if (state_reg == adcsg_pkg::ST_EMIT) begin
				res_valid_reg <= 1'b1;
				res_reg.grp <= grp_reg;
				res_reg.chan <= cur_chan_reg;
				res_reg.data <= acc_on ? (acc_sum >> acc_shift(acc_reg)) : acc_sum;
			end
			if (go_a || go_b) begin
				state_reg <= adcsg_pkg::ST_ISSUE;
				grp_reg <= go_b;
				idx_reg <= '0;
				rep_reg <= '0;
			end else begin
				case (state_reg)
					adcsg_pkg::ST_IDLE: state_reg <= adcsg_pkg::ST_IDLE;
					adcsg_pkg::ST_ISSUE: begin
						if (pick_found) begin
							conv_req_reg <= 1'b1;
							conv_chan_reg <= pick_chan;
							cur_chan_reg <= pick_chan;
							state_reg <= adcsg_pkg::ST_WAIT;
						end else begin
							state_reg <= adcsg_pkg::ST_IDLE;
						end
					end
					adcsg_pkg::ST_WAIT: begin
						if (conv_done && rep_inc < reps) begin
							rep_reg <= rep_inc;
							state_reg <= adcsg_pkg::ST_ISSUE;
						end else if (conv_done) begin
							state_reg <= adcsg_pkg::ST_EMIT;
						end
					end
					adcsg_pkg::ST_EMIT: begin
						idx_reg <= cur_chan_reg + adcsg_pkg::ONE_REP;
						rep_reg <= '0;
						state_reg <= adcsg_pkg::ST_ISSUE;
					end
					default: state_reg <= adcsg_pkg::ST_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** verification/adcsg_monitor.sv ***
// Purpose: Port-level assertions for the scan control block
// Assumes: Settings are mirrored from APB writes seen at the ports
// Notes: Masks and modes are changed only between scans, except priority and continuous bits
`timescale 1ns/1ns
`default_nettype none
module adcsg_monitor (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [adcsg_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic conv_req,
	input wire logic [adcsg_pkg::CH_W-1:0] conv_chan,
	input wire logic conv_done,
	input wire logic res_valid,
	input wire adcsg_pkg::adcsg_res_t res
);
	logic [6:0] ctrl;
	logic [29:0] sel_a, sel_b, accm;
	logic [4:0] n;
	logic [4:0] want;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= '0;
			sel_a <= '0;
			sel_b <= '0;
			accm <= '0;
		end else if (psel && penable && pready && pwrite) begin
			case (paddr)
				adcsg_pkg::OFF_CTRL: ctrl <= pwdata[6:0];
				adcsg_pkg::OFF_SEL_A: sel_a <= pwdata[29:0];
				adcsg_pkg::OFF_SEL_B: sel_b <= pwdata[29:0];
				adcsg_pkg::OFF_ACC_MASK: accm <= pwdata[29:0];
				default: ;
			endcase
		end
	end
	// Conversions answered since the last result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			n <= '0;
		else if (res_valid)
			n <= '0;
		else if (conv_done)
			n <= n + 5'h01;
	end
	function automatic logic [4:0] reps(input logic [2:0] c, input logic m);
		if (!m || c == 3'h0 || c == 3'h7) return 5'h01;
		if (c == 3'h4) return 5'h10;
		if (c > 3'h4) return (c == 3'h5) ? 5'h02 : 5'h04;
		return {2'h0, c} + 5'h01;
	endfunction
	assign want = reps(ctrl[6:4], accm[res.chan]);
	sequence apb_access;
		psel && penable && !pready;
	endsequence
	chk_ready_wait: assert property (apb_access |=> pready)
		else $error("pready missing after access");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_unmapped: assert property (pready && paddr[1:0] == 2'h0
		|-> pslverr == (paddr > adcsg_pkg::OFF_RESULT))
		else $error("pslverr wrong for address");
	chk_normal_mask: assert property (conv_req && !ctrl[0] |-> sel_a[conv_chan])
		else $error("normal scan converts unselected channel");
	chk_group_mask: assert property (conv_req && ctrl[0] |-> (sel_a[conv_chan] || sel_b[conv_chan]))
		else $error("group scan converts unassigned channel");
	chk_b_member: assert property (res_valid && ctrl[0] && res.grp
		|-> sel_b[res.chan] && !sel_a[res.chan])
		else $error("group B result for non-member");
	chk_rep_count: assert property (res_valid |-> n == want)
		else $error("wrong number of conversions per result");
	chk_narrow_result: assert property (res_valid && (want == 5'h01 || ctrl[6:4] > 3'h4)
		|-> res.data[15:12] == 4'h0)
		else $error("single or averaged result too wide");
	chk_done_answer: assert property (conv_done |-> ##2 (res_valid || conv_req))
		else $error("no follow-up after conversion");
	chk_res_stable: assert property (!res_valid |-> $stable(res))
		else $error("result changed without valid");
endmodule
bind adcsg_top adcsg_monitor adcsg_monitor_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .conv_req(conv_req), .conv_chan(conv_chan),
	.conv_done(conv_done), .res_valid(res_valid), .res(res));
`default_nettype wire

// *** verification/adcsg_tb.sv ***
// Purpose: Directed test of scan masks, accumulation and group priority
// Assumes: Bench answers every conversion request three cycles later
// Notes: Sample value is 0x800 plus channel, so sums identify repeat counts
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic trig_a, trig_b, conv_req, conv_done, res_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [4:0] conv_chan, ch;
	logic [11:0] conv_data;
	logic [2:0] cnt;
	adcsg_pkg::adcsg_res_t res;
	logic [21:0] q [$];
	logic [4:0] chs [4] = '{5'h00, 5'h02, 5'h1c, 5'h1d};
	logic [5:0] ord [4][6];
	int lens [4];
	int errors, num_checks;
	adcsg_top adcsg_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .event_link_trigger_a(trig_a), .event_link_trigger_b(trig_b),
		.conv_req(conv_req), .conv_chan(conv_chan), .conv_done(conv_done),
		.conv_data(conv_data), .res_valid(res_valid), .res(res));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Data toggles outside conv_done so a stale sample cannot pass
	always @(posedge pclk) begin
		if (cnt != 3'h0) cnt <= cnt - 3'h1;
		if (cnt == 3'h1) begin
			conv_done <= 1'b1;
			conv_data <= 12'h800 | {7'h00, ch};
		end else begin
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
		end
		if (conv_req === 1'b1) begin
			cnt <= 3'h3;
			ch <= conv_chan;
		end
		if (res_valid === 1'b1) q.push_back(res);
	end
	task close_out;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 50) begin
			errors++;
			close_out;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_res(input int n);
		for (int i = 0; i < 3000 && q.size() < n; i++) @(posedge pclk);
		if (q.size() < n) begin
			check("result count", n, q.size());
			close_out;
		end
	endtask
	task pulse(input logic b);
		@(posedge pclk);
		trig_a <= !b;
		trig_b <= b;
		@(posedge pclk);
		trig_a <= 1'b0;
		trig_b <= 1'b0;
	endtask
	task cres(input logic g, input logic [4:0] c, input logic [15:0] d);
		logic [21:0] got;
		got = q.pop_front();
		check("result", {10'h000, g, c, d}, {10'h000, got});
	endtask
	function automatic logic [15:0] accv(input int c, input logic [11:0] d, input logic m);
		int n;
		// Mean of equal samples is the sample itself
		n = (!m || c == 0 || c > 4) ? 1 : (c == 4) ? 16 : c + 1;
		return 16'(n) * {4'h0, d};
	endfunction
	initial begin
		{psel, penable, pwrite, trig_a, trig_b, presetn, conv_done} = '0;
		paddr = '0;
		pwdata = '0;
		conv_data = '0;
		cnt = '0;
		ch = '0;
		errors = 0;
		num_checks = 0;
		ord = '{'{6'h21, 6'h22, 6'h3c, 6'h00, 6'h00, 6'h00},
			'{6'h21, 6'h00, 6'h00, 6'h00, 6'h00, 6'h00},
			'{6'h21, 6'h00, 6'h21, 6'h22, 6'h3c, 6'h00},
			'{6'h21, 6'h00, 6'h21, 6'h22, 6'h3c, 6'h21}};
		lens = '{4, 2, 5, 6};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0000_0000);
			check("reset value", 32'h0000_0000, rd);
		end
		apb(1'b0, 8'h20, 32'h0000_0000);
		check("unmapped error", 32'h0000_0001, 32'(err));
		apb(1'b1, adcsg_pkg::OFF_SEL_A, 32'h3000_0005);
		apb(1'b1, adcsg_pkg::OFF_ACC_MASK, 32'h2000_0001);
		for (int c = 0; c < 8; c++) begin
			apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0100 | 32'(c << 4));
			wait_res(4);
			for (int k = 0; k < 4; k++)
				cres(1'b0, chs[k], accv(c, 12'h800 | chs[k], k == 0 || k == 3));
		end
		// Continuous normal scan loops until the mode bit is cleared
		apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0102);
		wait_res(5);
		for (int k = 0; k < 5; k++)
			cres(1'b0, chs[k % 4], 16'h0800 | 16'(chs[k % 4]));
		apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0000);
		repeat (40) @(posedge pclk);
		q.delete();
		repeat (100) @(posedge pclk);
		check("continuous stop", 32'h0000_0000, q.size());
		apb(1'b1, adcsg_pkg::OFF_SEL_A, 32'h0000_0001);
		apb(1'b1, adcsg_pkg::OFF_SEL_B, 32'h1000_0006);
		apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0001);
		apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0101);
		repeat (100) @(posedge pclk);
		check("software start in group mode", 32'h0000_0000, q.size());
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0001 | 32'(p << 2));
			pulse(1'b1);
			repeat (2) @(posedge pclk);
			pulse(1'b0);
			wait_res(lens[p]);
			// Dropping to the reset policy ends the endless group B loop
			if (p == 3) apb(1'b1, adcsg_pkg::OFF_CTRL, 32'h0000_0001);
			repeat (200) @(posedge pclk);
			if (p != 3) check("result count", lens[p], q.size());
			for (int k = 0; k < lens[p]; k++)
				cres(ord[p][k][5], ord[p][k][4:0], {11'h000, ord[p][k][4:0]} | 16'h0800);
			q.delete();
		end
		close_out;
	end
endmodule
`default_nettype wire
